// ==== rtl/scsc_standby_ctrl.sv ====
// Functional notes
// - 21-stage divider behind divide-by-4 prescaler
// - Reset, stop entry, stop release and warm-up end clear divider
// - Single clock: fc/256 feeds stage 7
// - Dual high: stage 7 source select bit
// - Low main clock: fs to stage 7
// - Machine cycle is four states S0-S3
// - Instructions take one to ten cycles
// - Reset option picks single or dual
// - Single clock: high oscillator only, pins free
// - Idle bit enters single CPU halt
// - Any interrupt ends single CPU halt
// - Wake: service interrupt if master flag set
// - Deep stop halts all, ports hold/float
// - Stop bit enters stop, pin releases
// - Dual: main clock from fc or fs
// - Slow stops fc; switched by main select
// - Dual halt returns to dual full speed
// - Divider supplies warm-up and peripheral clocks
// - Warm-up select: triple or single length
// - Both oscillator enables clear gives reset
// - Sleep runs fs only, returns to slow
`include "scsc_params.svh"

module scsc_standby_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Pins
    input wire logic dualClockOption,
    input wire logic highOscIn,
    input wire logic lowOscIn,
    input wire logic stopPin,
    // System control one
    input wire logic stopStart,
    input wire logic releaseLevel,
    input wire logic returnSlow,
    input wire logic outputHoldSel,
    input wire logic [1:0] warmupTimeSelect,
    // System control two and time base
    input wire logic highOscEnable,
    input wire logic lowOscEnable,
    input wire logic mainClockSelect,
    input wire logic idleStart,
    input wire logic stage7SourceSelect,
    // CPU side
    input wire logic interruptRequest,
    input wire logic interruptMasterFlag,
    input wire logic instrStart,
    input wire logic [3:0] instrCycles,
    // Mode and clock status
    output logic dualMode,
    output logic mainClockMonitor,
    output logic mainClockTick,
    output logic [`SCSC_STATES-1:0] stateEnable,
    output logic instrDone,
    output logic cpuRun,
    output logic watchdogRun,
    output logic peripheralRun,
    output logic highOscRun,
    output logic lowOscRun,
    output logic lowPinsAsPort,
    output logic portHighZ,
    output logic serviceInterrupt,
    output logic resetRequest,
    output logic [`SCSC_DIV_STAGES-1:0] dividerOut
);

    scsc_pkg::scsc_mode_t mode;
    scsc_pkg::scsc_mode_t next_mode;
    logic [1:0] optSync;
    logic [1:0] highSync;
    logic [1:0] lowSync;
    logic [1:0] stopSync;
    logic highLast;
    logic lowLast;
    logic stopLast;
    logic highEdge;
    logic lowEdge;
    logic stopRise;
    logic highTick;
    logic lowTick;
    logic lowMain;
    logic levelArmed;
    logic releaseNow;
    logic warmLow;
    logic warmLong;
    logic [1:0] warmCount;
    logic warmDone;
    logic dividerClear;
    logic carryHigh;
    logic carryLow;
    logic [`SCSC_DIV_STAGES-1:0] divider;
    logic [3:0] cycleCount;
    logic instrBusy;
    logic cpuClockTick;

    function automatic logic warmTarget(input logic [1:0] sel, input logic [1:0] count);
        warmTarget = (sel == `SCSC_WUT_LONG) ? (count == `SCSC_WARM_LONG_COUNT)
            : (count == `SCSC_WARM_SHORT_COUNT);
    endfunction

    // Pin synchronisers; edges are taken from the second stage only
    always_ff @(posedge clock)
    begin
        optSync <= {optSync[0], dualClockOption};
        highSync <= {highSync[0], highOscIn};
        lowSync <= {lowSync[0], lowOscIn};
        stopSync <= {stopSync[0], stopPin};
        highLast <= highSync[1];
        lowLast <= lowSync[1];
        stopLast <= stopSync[1];
    end

    assign highEdge = highSync[1] && !highLast;
    assign lowEdge = lowSync[1] && !lowLast;
    assign stopRise = stopSync[1] && !stopLast;

    // A stopped oscillator gives no ticks
    assign highTick = highEdge && highOscRun;
    assign lowTick = lowEdge && lowOscRun;
    assign lowMain = dualMode && (mode == scsc_pkg::MODE_SLOW || mode == scsc_pkg::MODE_SLEEP
        || (mode == scsc_pkg::MODE_WARM && warmLow));

    // Option strap held through reset, caught on clocked edges
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            dualMode <= optSync[1];
    end

    // Switching to level release waits for a rising edge on the pin
    always_ff @(posedge clock)
    begin
        if (!rst_b || !releaseLevel)
            levelArmed <= 1'b0;
        else if (stopRise)
            levelArmed <= 1'b1;
    end

    assign releaseNow = (levelArmed && stopSync[1]) || (!levelArmed && stopRise);

    always_comb
    begin
        next_mode = mode;
        case (mode)
            scsc_pkg::MODE_FULL:
            begin
                if (stopStart)
                    next_mode = (levelArmed && stopSync[1]) ? scsc_pkg::MODE_WARM
                        : scsc_pkg::MODE_STOP;
                else if (idleStart)
                    next_mode = scsc_pkg::MODE_HALT;
                else if (dualMode && mainClockSelect)
                    next_mode = scsc_pkg::MODE_SLOW;
            end
            scsc_pkg::MODE_SLOW:
            begin
                if (stopStart)
                    next_mode = (levelArmed && stopSync[1]) ? scsc_pkg::MODE_WARM
                        : scsc_pkg::MODE_STOP;
                else if (idleStart)
                    next_mode = scsc_pkg::MODE_SLEEP;
                else if (!mainClockSelect)
                    next_mode = scsc_pkg::MODE_FULL;
            end
            scsc_pkg::MODE_HALT:
            begin
                if (interruptRequest)
                    next_mode = scsc_pkg::MODE_FULL;
            end
            scsc_pkg::MODE_SLEEP:
            begin
                if (interruptRequest)
                    next_mode = scsc_pkg::MODE_SLOW;
            end
            scsc_pkg::MODE_STOP:
            begin
                if (releaseNow)
                    next_mode = scsc_pkg::MODE_WARM;
            end
            scsc_pkg::MODE_WARM:
            begin
                if (warmDone)
                    next_mode = warmLow ? scsc_pkg::MODE_SLOW : scsc_pkg::MODE_FULL;
            end
            default:
                next_mode = scsc_pkg::MODE_FULL;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            mode <= scsc_pkg::MODE_FULL;
        else
            mode <= next_mode;
    end

    // Return target is latched as stop is entered
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            warmLow <= 1'b0;
            warmLong <= 1'b0;
        end
        else if (stopStart && (mode == scsc_pkg::MODE_FULL || mode == scsc_pkg::MODE_SLOW))
        begin
            warmLow <= dualMode && returnSlow;
            warmLong <= (warmupTimeSelect == `SCSC_WUT_LONG);
        end
    end

    // Warm-up counts divider carries: 2^19/fc or 2^13/fs each
    always_ff @(posedge clock)
    begin
        if (!rst_b || mode != scsc_pkg::MODE_WARM)
            warmCount <= 2'h0;
        else if (warmLow ? carryLow : carryHigh)
            warmCount <= warmCount + 2'h1;
    end

    assign warmDone = warmTarget(warmLong ? `SCSC_WUT_LONG : `SCSC_WUT_SHORT, warmCount);

    // Divider cleared entering warm-up and again when it ends
    assign dividerClear = (mode == scsc_pkg::MODE_STOP && releaseNow)
        || (mode == scsc_pkg::MODE_FULL && stopStart)
        || (mode == scsc_pkg::MODE_SLOW && stopStart)
        || (mode == scsc_pkg::MODE_WARM && warmDone);

    scsc_divider u_divider (
        .clock(clock),
        .rst_b(rst_b),
        .clear(dividerClear),
        .lowStagesRun(!lowMain),
        .stage7FromLow(lowMain || (dualMode && stage7SourceSelect && mode != scsc_pkg::MODE_WARM)),
        .highTick(highTick),
        .lowTick(lowTick),
        .divider(divider),
        .carryHigh(carryHigh),
        .carryLow(carryLow)
    );

    // Oscillator and domain run flags
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            highOscRun <= 1'b1;
            lowOscRun <= 1'b0;
            lowPinsAsPort <= 1'b1;
        end
        else
        begin
            highOscRun <= highOscEnable && !(next_mode == scsc_pkg::MODE_STOP)
                && !(dualMode && (next_mode == scsc_pkg::MODE_SLOW || next_mode == scsc_pkg::MODE_SLEEP
                || (next_mode == scsc_pkg::MODE_WARM && warmLow)));
            lowOscRun <= dualMode && lowOscEnable && next_mode != scsc_pkg::MODE_STOP;
            lowPinsAsPort <= !dualMode;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            cpuRun <= 1'b1;
            watchdogRun <= 1'b1;
            peripheralRun <= 1'b1;
            portHighZ <= 1'b0;
            mainClockMonitor <= 1'b0;
        end
        else
        begin
            cpuRun <= next_mode == scsc_pkg::MODE_FULL || next_mode == scsc_pkg::MODE_SLOW;
            watchdogRun <= next_mode == scsc_pkg::MODE_FULL || next_mode == scsc_pkg::MODE_SLOW;
            peripheralRun <= next_mode != scsc_pkg::MODE_STOP && next_mode != scsc_pkg::MODE_WARM;
            portHighZ <= (next_mode == scsc_pkg::MODE_STOP || next_mode == scsc_pkg::MODE_WARM)
                && !outputHoldSel;
            mainClockMonitor <= lowMain;
        end
    end

    // Wake-up service decision
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            serviceInterrupt <= 1'b0;
        else
            serviceInterrupt <= interruptRequest && interruptMasterFlag
                && (mode == scsc_pkg::MODE_HALT || mode == scsc_pkg::MODE_SLEEP);
    end

    // Both oscillators off is fatal, so the device resets itself
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            resetRequest <= 1'b0;
        else
            resetRequest <= !highOscEnable && !lowOscEnable;
    end

    // Main system clock: one fc or fs period per state
    assign cpuClockTick = lowMain ? lowTick : highTick;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            mainClockTick <= 1'b0;
        else
            mainClockTick <= cpuClockTick && mode != scsc_pkg::MODE_STOP
                && mode != scsc_pkg::MODE_WARM;
    end

    // State enables rotate S0..S3 and hold while the CPU is halted
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            stateEnable <= `SCSC_STATE_S0;
        else if (cpuClockTick && (mode == scsc_pkg::MODE_FULL || mode == scsc_pkg::MODE_SLOW))
            stateEnable <= {stateEnable[`SCSC_STATES-2:0], stateEnable[`SCSC_STATES-1]};
    end

    // Machine cycle counter: done pulse after the requested cycle count
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            cycleCount <= 4'h0;
            instrBusy <= 1'b0;
            instrDone <= 1'b0;
        end
        else
        begin
            instrDone <= 1'b0;
            if (instrStart && !instrBusy)
            begin
                cycleCount <= (instrCycles == 4'h0) ? 4'h1
                    : (instrCycles > `SCSC_MAX_CYCLES) ? `SCSC_MAX_CYCLES : instrCycles;
                instrBusy <= 1'b1;
            end
            else if (instrBusy && cpuRun && cpuClockTick && stateEnable[`SCSC_STATES-1])
            begin
                if (cycleCount == 4'h1)
                begin
                    instrBusy <= 1'b0;
                    instrDone <= 1'b1;
                end
                cycleCount <= cycleCount - 4'h1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            dividerOut <= '0;
        else
            dividerOut <= divider;
    end

endmodule

// ==== common/scsc_params.svh ====
`ifndef SCSC_PARAMS_SVH
`define SCSC_PARAMS_SVH

// Divider chain shape
`define SCSC_DIV_STAGES 21
`define SCSC_LOW_STAGES 6
`define SCSC_PRESC_WIDTH 2
// Stage whose carry marks 2^19 high periods, and 2^13 low periods
`define SCSC_WARM_HIGH_STAGE 17
`define SCSC_WARM_LOW_STAGE 19
// Warm-up select field codes and carry counts
`define SCSC_WUT_LONG 2'h0
`define SCSC_WUT_SHORT 2'h1
`define SCSC_WARM_LONG_COUNT 2'h3
`define SCSC_WARM_SHORT_COUNT 2'h1
// Machine cycle
`define SCSC_STATES 4
`define SCSC_STATE_S0 4'h1
`define SCSC_MAX_CYCLES 4'ha

`endif

// ==== common/scsc_pkg.sv ====
package scsc_pkg;

    typedef enum {
        MODE_FULL,
        MODE_HALT,
        MODE_SLOW,
        MODE_SLEEP,
        MODE_STOP,
        MODE_WARM
    } scsc_mode_t;

endpackage

// ==== rtl/scsc_divider.sv ====
`include "scsc_params.svh"

module scsc_divider (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Control
    input wire logic clear,
    input wire logic lowStagesRun,
    input wire logic stage7FromLow,
    // Oscillator ticks
    input wire logic highTick,
    input wire logic lowTick,
    // Outputs
    output logic [`SCSC_DIV_STAGES-1:0] divider,
    output logic carryHigh,
    output logic carryLow
);

    logic [`SCSC_PRESC_WIDTH-1:0] presc;
    logic prescTick;
    logic stage7Tick;
    // Two words so that each half of the chain has a single writer
    logic [`SCSC_LOW_STAGES-1:0] lowStages;
    logic [`SCSC_DIV_STAGES-`SCSC_LOW_STAGES-1:0] highStages;

    assign divider = {highStages, lowStages};

    assign prescTick = highTick && (presc == {`SCSC_PRESC_WIDTH{1'b1}});
    // Stage 7 takes fc/256 from stage 6, or fs directly
    assign stage7Tick = stage7FromLow ? lowTick
        : (prescTick && lowStagesRun && (lowStages == {`SCSC_LOW_STAGES{1'b1}}));

    // Prescaler is untouched by the divider clear
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            presc <= '0;
        else if (highTick)
            presc <= presc + 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b || clear)
            lowStages <= '0;
        else if (!lowStagesRun)
            lowStages <= '0;
        else if (prescTick)
            lowStages <= lowStages + 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b || clear)
            highStages <= '0;
        else if (stage7Tick)
            highStages <= highStages + 1'b1;
    end

    // Warm-up timing carries
    always_ff @(posedge clock)
    begin
        if (!rst_b || clear)
        begin
            carryHigh <= 1'b0;
            carryLow <= 1'b0;
        end
        else
        begin
            carryHigh <= stage7Tick
                && (&highStages[`SCSC_WARM_HIGH_STAGE-`SCSC_LOW_STAGES-1:0]);
            carryLow <= stage7Tick
                && (&highStages[`SCSC_WARM_LOW_STAGE-`SCSC_LOW_STAGES-1:0]);
        end
    end

endmodule

// ==== testbench/scsc_standby_ctrl_monitor.sv ====
`include "scsc_params.svh"

module scsc_standby_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Watched inputs
    input wire logic stopStart,
    input wire logic releaseLevel,
    input wire logic outputHoldSel,
    input wire logic highOscEnable,
    input wire logic lowOscEnable,
    input wire logic idleStart,
    input wire logic interruptRequest,
    input wire logic interruptMasterFlag,
    // Watched outputs
    input wire logic dualMode,
    input wire logic mainClockMonitor,
    input wire logic [`SCSC_STATES-1:0] stateEnable,
    input wire logic instrDone,
    input wire logic cpuRun,
    input wire logic watchdogRun,
    input wire logic peripheralRun,
    input wire logic highOscRun,
    input wire logic lowOscRun,
    input wire logic lowPinsAsPort,
    input wire logic portHighZ,
    input wire logic serviceInterrupt,
    input wire logic resetRequest,
    input wire logic [`SCSC_DIV_STAGES-1:0] dividerOut
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_state_one_hot: assert property ($onehot(stateEnable))
        else $error("state enables not one-hot");
    a_state_freeze: assert property (!cpuRun && !$past(cpuRun) |-> $stable(stateEnable))
        else $error("states moved while cpu halted");
    a_halt_wake: assert property (!cpuRun && peripheralRun && interruptRequest |=> cpuRun)
        else $error("interrupt did not end halt");
    a_wake_service: assert property (serviceInterrupt |-> cpuRun && $past(interruptMasterFlag))
        else $error("service pulse without master flag");
    a_idle_entry: assert property (idleStart && !stopStart && cpuRun
        |=> !cpuRun && !watchdogRun && peripheralRun)
        else $error("idle bit did not halt cpu");
    a_stop_entry: assert property (stopStart && cpuRun && !releaseLevel
        |=> !cpuRun && !highOscRun && !peripheralRun && portHighZ == !$past(outputHoldSel))
        else $error("stop entry outputs wrong");
    // The divider copy lags the entry clear by a cycle, so look two cycles back
    a_stop_frozen: assert property (!highOscRun && !lowOscRun && !$past(highOscRun, 2)
        && !$past(lowOscRun, 2) |-> $stable(dividerOut))
        else $error("divider moved in stop");
    a_slow_low_stages: assert property (mainClockMonitor && $past(mainClockMonitor)
        && $past(mainClockMonitor, 2) |-> $stable(dividerOut[5:0]))
        else $error("low stages ran on low main clock");
    a_reset_request: assert property (resetRequest == (!$past(highOscEnable) && !$past(lowOscEnable)))
        else $error("reset request wrong");
    a_pins_port: assert property ($past(rst_b) |-> lowPinsAsPort == !dualMode)
        else $error("low oscillator pin use wrong");
    a_single_high: assert property (!dualMode |-> !mainClockMonitor)
        else $error("low main clock in single mode");
    a_done_pulse: assert property (instrDone |=> !instrDone)
        else $error("done longer than one cycle");
endmodule

bind scsc_standby_ctrl scsc_standby_monitor u_mon (.clock, .rst_b, .stopStart, .releaseLevel,
    .outputHoldSel, .highOscEnable, .lowOscEnable, .idleStart, .interruptRequest, .interruptMasterFlag,
    .dualMode, .mainClockMonitor, .stateEnable, .instrDone, .cpuRun, .watchdogRun, .peripheralRun,
    .highOscRun, .lowOscRun, .lowPinsAsPort, .portHighZ, .serviceInterrupt, .resetRequest, .dividerOut);

// ==== testbench/scsc_cpu_model.sv ====
module scsc_cpu_model (
    // Clock
    input wire logic clock,
    // Design outputs
    input wire logic [3:0] stateEnable,
    input wire logic instrDone,
    input wire logic cpuRun,
    input wire logic serviceInterrupt,
    // Design inputs
    output logic instrStart,
    output logic [3:0] instrCycles,
    output logic interruptRequest,
    output logic interruptMasterFlag
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        instrStart = 1'b0;
        instrCycles = 4'h0;
        interruptRequest = 1'b0;
        interruptMasterFlag = 1'b0;
    end

    // Counts S3 to S0 wraps from the taking edge up to done
    task automatic run(input logic [3:0] n, output int w);
        logic [3:0] last;
        int k;
        w = 0;
        @(posedge clock);
        #2;
        instrStart = 1'b1;
        instrCycles = n;
        @(posedge clock);
        #2;
        instrStart = 1'b0;
        // Cycle count is no longer qualified, so it must not look stable
        instrCycles = ~n;
        last = stateEnable;
        for (k = 0; k < 3000 && instrDone !== 1'b1; k++)
        begin
            @(posedge clock);
            #2;
            if (last === 4'h8 && stateEnable === 4'h1)
                w++;
            last = stateEnable;
        end
    endtask

    // Interrupt request held until the cpu runs again
    task automatic wake(input logic interrupt_master_flag, output logic svc);
        int k;
        svc = 1'b0;
        interruptMasterFlag = interrupt_master_flag;
        interruptRequest = 1'b1;
        for (k = 0; k < 50 && cpuRun !== 1'b1; k++)
        begin
            @(posedge clock);
            #2;
            if (serviceInterrupt === 1'b1)
                svc = 1'b1;
        end
        interruptRequest = 1'b0;
    endtask
endmodule

// ==== testbench/tb_system_clock_standby_controller.sv ====
module tb_system_clock_standby_controller;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0, rst_b = 1'b0, dualClockOption = 1'b0, highOscIn = 1'b0, lowOscIn = 1'b0;
    logic stopStart = 1'b0, stopPin = 1'b0, outputHoldSel = 1'b1, idleStart = 1'b0, returnSlow = 1'b0;
    logic highOscEnable = 1'b1, lowOscEnable = 1'b0, mainClockSelect = 1'b0, stage7SourceSelect = 1'b0;
    logic [1:0] warmupTimeSelect = 2'h0;
    logic instrStart, interruptRequest, interruptMasterFlag, svc;
    logic [3:0] instrCycles;
    logic dualMode, mainClockMonitor, mainClockTick, instrDone, cpuRun, watchdogRun, peripheralRun;
    logic highOscRun, lowOscRun, lowPinsAsPort, portHighZ, serviceInterrupt, resetRequest;
    logic [3:0] stateEnable, st;
    logic [20:0] dividerOut, dv;
    int n_errors = 0, n_checks = 0, cyc = 0, oscCount = 0, w, k, n;
    int expq[$];

    scsc_standby_ctrl dut (.clock, .rst_b, .dualClockOption, .highOscIn, .lowOscIn, .stopPin,
        .stopStart, .releaseLevel(1'b0), .returnSlow, .outputHoldSel, .warmupTimeSelect, .highOscEnable,
        .lowOscEnable, .mainClockSelect, .idleStart, .stage7SourceSelect, .interruptRequest,
        .interruptMasterFlag, .instrStart, .instrCycles, .dualMode, .mainClockMonitor, .mainClockTick,
        .stateEnable, .instrDone, .cpuRun, .watchdogRun, .peripheralRun, .highOscRun, .lowOscRun,
        .lowPinsAsPort, .portHighZ, .serviceInterrupt, .resetRequest, .dividerOut);

    scsc_cpu_model cpu (.clock, .stateEnable, .instrDone, .cpuRun, .serviceInterrupt, .instrStart,
        .instrCycles, .interruptRequest, .interruptMasterFlag);

    initial
    begin
        forever #25 clock = ~clock;
    end

    // Oscillators run free; the design alone decides when ticks count
    always @(posedge clock)
    begin
        #2;
        oscCount = oscCount + 1;
        highOscIn = oscCount[1];
        lowOscIn = oscCount[4];
        cyc = cyc + 1;
        if (cyc == 40000)
        begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge clock);
        #2;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask

    task automatic waitMain(input logic v);
        for (k = 0; k < 500 && mainClockMonitor !== v; k++)
            step(1);
        chk("mainClockMonitor", v, mainClockMonitor);
    endtask

    task automatic test_done();
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        void'($urandom(1));
        // Strap needs three edges to pass its synchroniser
        step(3);
        chk("stateEnable", 4'h1, stateEnable);
        chk("dividerOut", 0, dividerOut);
        chk("cpuRun", 1, cpuRun);
        rst_b = 1'b1;
        step(1);
        chk("dualMode", 0, dualMode);
        chk("lowPinsAsPort", 1, lowPinsAsPort);
        stage7SourceSelect = 1'($urandom_range(0, 1));
        warmupTimeSelect = 2'($urandom_range(0, 3));
        cpu.run(4'h1, w);
        for (int i = 0; i < 7; i++)
        begin
            n = (i == 0) ? 0 : (i == 1) ? 15 : (i == 2) ? 10 : $urandom_range(1, 15);
            expq.push_back(n == 0 ? 1 : (n > 10 ? 10 : n));
            cpu.run(4'(n), w);
            chk("machine cycles", expq.pop_front(), w);
        end
        for (int interrupt_master_flag = 1; interrupt_master_flag >= 0; interrupt_master_flag--)
        begin
            pulse(idleStart);
            chk("cpuRun", 0, cpuRun);
            chk("watchdogRun", 0, watchdogRun);
            chk("peripheralRun", 1, peripheralRun);
            st = stateEnable;
            step(12);
            chk("stateEnable", st, stateEnable);
            cpu.wake(1'(interrupt_master_flag), svc);
            chk("cpuRun", 1, cpuRun);
            chk("serviceInterrupt", interrupt_master_flag, svc);
        end
        // One divider count per four fc periods; fc rises every fourth clock here
        dv = dividerOut;
        n = 0;
        repeat (1024)
        begin
            step(1);
            n = n + ((mainClockTick === 1'b1) ? 1 : 0);
        end
        chk("divider count", 64, 21'(dividerOut - dv));
        chk("mainClockTick count", 256, n);
        highOscEnable = 1'b0;
        step(2);
        chk("resetRequest", 1, resetRequest);
        highOscEnable = 1'b1;
        step(2);
        chk("resetRequest", 0, resetRequest);
        outputHoldSel = 1'b0;
        pulse(stopStart);
        chk("highOscRun", 0, highOscRun);
        chk("portHighZ", 1, portHighZ);
        chk("cpuRun", 0, cpuRun);
        dv = dividerOut;
        step(20);
        chk("dividerOut", dv, dividerOut);
        // Pin edge passes two sync stages, then starts the warm-up
        stopPin = 1'b1;
        step(3);
        chk("highOscRun", 1, highOscRun);
        chk("cpuRun", 0, cpuRun);
        rst_b = 1'b0;
        dualClockOption = 1'b1;
        lowOscEnable = 1'b1;
        returnSlow = 1'($urandom_range(0, 1));
        step(4);
        rst_b = 1'b1;
        step(2);
        chk("dualMode", 1, dualMode);
        chk("lowPinsAsPort", 0, lowPinsAsPort);
        chk("lowOscRun", 1, lowOscRun);
        mainClockSelect = 1'b1;
        waitMain(1'b1);
        chk("highOscRun", 0, highOscRun);
        cpu.run(4'h2, w);
        cpu.run(4'h2, w);
        chk("slow cycles", 2, w);
        pulse(idleStart);
        chk("cpuRun", 0, cpuRun);
        chk("lowOscRun", 1, lowOscRun);
        cpu.wake(1'b1, svc);
        chk("serviceInterrupt", 1, svc);
        chk("mainClockMonitor", 1, mainClockMonitor);
        mainClockSelect = 1'b0;
        waitMain(1'b0);
        chk("highOscRun", 1, highOscRun);
        pulse(idleStart);
        chk("cpuRun", 0, cpuRun);
        chk("both oscillators", 2'h3, {highOscRun, lowOscRun});
        cpu.wake(1'b0, svc);
        chk("cpuRun", 1, cpuRun);
        chk("mainClockMonitor", 0, mainClockMonitor);
        test_done();
    end
endmodule
